/* File: rtl/cilm_top.sv */
// current input loss monitor with apb configuration port
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module cilm_top #(
   parameter int unsigned TICK_CYCLES = cilm_pkg::FILTER_TICK_CYCLES
) (
   input wire logic I_CLK_SYS,
   input wire logic I_NRST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire cilm_pkg::cilm_drv_in_t I_DRV,
   output cilm_pkg::cilm_drv_out_t O_DRV,
   output logic [cilm_pkg::NUM_TERMS-1:0] O_TERM
);

   function automatic logic legal_mode(input logic [15:0] v);
      legal_mode = (v >= cilm_pkg::MODE_HOLD && v <= cilm_pkg::MODE_FALLBACK) || v == cilm_pkg::CODE_UNSET;
   endfunction : legal_mode

   function automatic logic legal_fallback(input logic [15:0] v);
      legal_fallback = v <= cilm_pkg::FALLBACK_MAX || v == cilm_pkg::CODE_UNSET;
   endfunction : legal_fallback

   function automatic logic is_mode(input logic [15:0] m, input logic [15:0] code);
      is_mode = m == code;
   endfunction : is_mode

   // settings
   logic [15:0] loss_check_mode, next_loss_check_mode;
   logic term_sel, next_term_sel;
   logic [15:0] loss_fallback_frequency, next_loss_fallback_frequency;
   logic [15:0] loss_confirm_filter_time, next_loss_confirm_filter_time;
   logic [7:0] output_terminal_function_select, next_output_terminal_function_select;
   logic [cilm_pkg::NUM_TERMS-1:0] term_mask, next_term_mask;
   logic [31:0] prdata, next_prdata;
   logic pslverr, next_pslverr;
   logic pready;
   logic wr_en, setup;
   logic fault_clr;

   assign setup = I_PSEL && !I_PENABLE;
   assign wr_en = I_PSEL && I_PENABLE && pready && I_PWRITE;

   // monitor state
   cilm_pkg::cilm_state_t state, next_state;
   logic [15:0] eff_mode, next_eff_mode;
   logic [15:0] eff_fallback, next_eff_fallback;
   logic [cilm_pkg::TICK_W-1:0] tick_cnt, next_tick_cnt;
   logic [cilm_pkg::HUND_W-1:0] hund_cnt, next_hund_cnt;
   logic [15:0] avg_prev, held, next_held;
   logic held_ok, next_held_ok;
   logic ms_seen, next_ms_seen;
   logic fault, next_fault;
   cilm_pkg::cilm_drv_out_t next_drv;
   logic [cilm_pkg::NUM_TERMS-1:0] next_term;
   logic [15:0] cur;
   logic check_en, low, restored, cond;

   // register file
   always_comb begin
      next_loss_check_mode = loss_check_mode;
      next_term_sel = term_sel;
      next_loss_fallback_frequency = loss_fallback_frequency;
      next_loss_confirm_filter_time = loss_confirm_filter_time;
      next_output_terminal_function_select = output_terminal_function_select;
      next_term_mask = term_mask;
      next_prdata = prdata;
      next_pslverr = pslverr;
      fault_clr = 1'b0;
      // decode in the setup phase so data and error are ready by the access edge
      if (setup) begin
         next_pslverr = 1'b0;
         unique case (I_PADDR)
            cilm_pkg::ADDR_CFG: begin
               next_prdata = {15'h0000, term_sel, loss_check_mode};
               next_pslverr = I_PWRITE && !legal_mode(I_PWDATA[15:0]);
            end
            cilm_pkg::ADDR_FALLBACK: begin
               next_prdata = {16'h0000, loss_fallback_frequency};
               next_pslverr = I_PWRITE && !legal_fallback(I_PWDATA[15:0]);
            end
            cilm_pkg::ADDR_FILTER: begin
               next_prdata = {16'h0000, loss_confirm_filter_time};
               next_pslverr = I_PWRITE && I_PWDATA[15:0] > cilm_pkg::FILTER_MAX;
            end
            cilm_pkg::ADDR_OUTSEL: begin
               next_prdata = {17'h00000, term_mask, output_terminal_function_select};
               next_pslverr = I_PWRITE && !(I_PWDATA[7:0] == cilm_pkg::FUNC_NONE
                  || I_PWDATA[7:0] == cilm_pkg::FUNC_ALARM_HIGH || I_PWDATA[7:0] == cilm_pkg::FUNC_ALARM_LOW);
            end
            cilm_pkg::ADDR_STATUS: begin
               next_prdata = {O_DRV.freq_cmd, 11'h000, held_ok, O_DRV.decel, state == cilm_pkg::ST_LOSS,
                  fault, O_DRV.alarm};
            end
            default: begin
               next_prdata = 32'h00000000;
               next_pslverr = 1'b1;
            end
         endcase
      end
      // refused writes leave the register untouched
      if (wr_en && !pslverr) begin
         unique case (I_PADDR)
            cilm_pkg::ADDR_CFG: begin
               next_loss_check_mode = I_PWDATA[15:0];
               next_term_sel = I_PWDATA[cilm_pkg::CFG_TERM_SEL_BIT];
            end
            cilm_pkg::ADDR_FALLBACK: next_loss_fallback_frequency = I_PWDATA[15:0];
            cilm_pkg::ADDR_FILTER: next_loss_confirm_filter_time = I_PWDATA[15:0];
            cilm_pkg::ADDR_OUTSEL: begin
               next_output_terminal_function_select = I_PWDATA[7:0];
               next_term_mask = I_PWDATA[cilm_pkg::OUTSEL_MASK_LSB +: cilm_pkg::NUM_TERMS];
            end
            cilm_pkg::ADDR_STATUS: fault_clr = I_PWDATA[cilm_pkg::ST_FAULT_BIT];
            default: fault_clr = 1'b0;
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         loss_check_mode <= cilm_pkg::CODE_UNSET;
         term_sel <= 1'b0;
         loss_fallback_frequency <= cilm_pkg::CODE_UNSET;
         loss_confirm_filter_time <= cilm_pkg::FILTER_RESET;
         output_terminal_function_select <= cilm_pkg::FUNC_NONE;
         term_mask <= '0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else begin
         loss_check_mode <= next_loss_check_mode;
         term_sel <= next_term_sel;
         loss_fallback_frequency <= next_loss_fallback_frequency;
         loss_confirm_filter_time <= next_loss_confirm_filter_time;
         output_terminal_function_select <= next_output_terminal_function_select;
         term_mask <= next_term_mask;
         prdata <= next_prdata;
         pslverr <= next_pslverr;
         pready <= 1'b1;
      end
   end

   assign O_PRDATA = prdata;
   assign O_PSLVERR = pslverr;
   assign O_PREADY = pready;

   // detection; low threshold ignores bias settings entirely
   assign cur = term_sel ? I_DRV.cur_secondary : I_DRV.cur_primary;
   assign check_en = (eff_mode >= cilm_pkg::MODE_HOLD && eff_mode <= cilm_pkg::MODE_FALLBACK)
      && !(is_mode(eff_mode, cilm_pkg::MODE_FALLBACK) && eff_fallback == cilm_pkg::CODE_UNSET);
   assign low = cur <= cilm_pkg::CUR_LOSS;
   // modes 3 and 4 recover at 3 mA itself, mode 1 only above it
   assign restored = (is_mode(eff_mode, cilm_pkg::MODE_DECEL) || is_mode(eff_mode, cilm_pkg::MODE_FALLBACK))
      ? cur >= cilm_pkg::CUR_RESTORE : cur > cilm_pkg::CUR_RESTORE;
   assign cond = (state == cilm_pkg::ST_NORMAL) ? low : restored;

   always_comb begin
      next_state = state;
      next_tick_cnt = tick_cnt;
      next_hund_cnt = hund_cnt;
      next_held = held;
      next_held_ok = held_ok;
      next_ms_seen = ms_seen;
      next_fault = fault;
      next_eff_mode = eff_mode;
      next_eff_fallback = eff_fallback;
      // mode and fallback settings only follow software while running and healthy
      if (I_DRV.run && !fault) begin
         next_eff_mode = loss_check_mode;
         next_eff_fallback = loss_fallback_frequency;
      end
      if (!check_en) begin
         next_state = cilm_pkg::ST_NORMAL;
         next_tick_cnt = '0;
         next_hund_cnt = '0;
      end else if (!cond) begin
         next_tick_cnt = '0;
         next_hund_cnt = '0;
      end else if ({5'h00, hund_cnt} >= loss_confirm_filter_time) begin
         next_tick_cnt = '0;
         next_hund_cnt = '0;
         if (state == cilm_pkg::ST_NORMAL) begin
            next_state = cilm_pkg::ST_LOSS;
            next_held = avg_prev;
            next_held_ok = 1'b1;
         end else begin
            next_state = cilm_pkg::ST_NORMAL;
         end
      end else if (tick_cnt == cilm_pkg::TICK_W'(TICK_CYCLES - 1)) begin
         next_tick_cnt = '0;
         next_hund_cnt = hund_cnt + 1'b1;
      end else begin
         next_tick_cnt = tick_cnt + 1'b1;
      end
      if (state == cilm_pkg::ST_LOSS && I_DRV.multi_speed) begin
         next_ms_seen = 1'b1;
      end else if (state == cilm_pkg::ST_NORMAL || !I_DRV.run) begin
         next_ms_seen = 1'b0;
      end
      if (!I_DRV.run) begin
         next_held_ok = 1'b0;
      end
      // set wins over a software clear in the same cycle
      if (fault_clr) begin
         next_fault = 1'b0;
      end
      if (check_en && state == cilm_pkg::ST_LOSS && (is_mode(eff_mode, cilm_pkg::MODE_TRIP)
         || (is_mode(eff_mode, cilm_pkg::MODE_DECEL) && I_DRV.standstill))) begin
         next_fault = 1'b1;
      end
   end

   // output stage
   always_comb begin
      // gated by check_en so a setting that disables the check silences the alarm as soon as it reaches eff_mode, which it does only while running and healthy
      next_drv.alarm = check_en && state == cilm_pkg::ST_LOSS && !is_mode(eff_mode, cilm_pkg::MODE_TRIP);
      next_drv.fault = fault;
      next_drv.shutoff = fault;
      next_drv.comp_en = state == cilm_pkg::ST_NORMAL;
      next_drv.decel = 1'b0;
      next_drv.freq_cmd = I_DRV.ref_freq;
      if (!I_DRV.run || fault) begin
         next_drv.freq_cmd = 16'h0000;
      end else if (I_DRV.multi_speed) begin
         next_drv.freq_cmd = I_DRV.ms_freq;
      end else if (state == cilm_pkg::ST_LOSS && check_en) begin
         next_drv.freq_cmd = 16'h0000;
         if (!ms_seen) begin
            unique case (eff_mode)
               cilm_pkg::MODE_HOLD: next_drv.freq_cmd = held_ok ? held : 16'h0000;
               cilm_pkg::MODE_DECEL: next_drv.decel = 1'b1;
               cilm_pkg::MODE_FALLBACK: next_drv.freq_cmd = 16'(eff_fallback * 16'h000A);
               default: next_drv.freq_cmd = 16'h0000;
            endcase
         end
      end
      for (int t = 0; t < cilm_pkg::NUM_TERMS; t++) begin
         next_term[t] = term_mask[t] && output_terminal_function_select != cilm_pkg::FUNC_NONE
            && (next_drv.alarm ^ (output_terminal_function_select == cilm_pkg::FUNC_ALARM_LOW));
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_NRST) begin
      if (!I_NRST) begin
         state <= cilm_pkg::ST_NORMAL;
         eff_mode <= cilm_pkg::CODE_UNSET;
         eff_fallback <= cilm_pkg::CODE_UNSET;
         tick_cnt <= '0;
         hund_cnt <= '0;
         avg_prev <= 16'h0000;
         held <= 16'h0000;
         held_ok <= 1'b0;
         ms_seen <= 1'b0;
         fault <= 1'b0;
         O_DRV <= '0;
         O_TERM <= '0;
      end else begin
         state <= next_state;
         eff_mode <= next_eff_mode;
         eff_fallback <= next_eff_fallback;
         tick_cnt <= next_tick_cnt;
         hund_cnt <= next_hund_cnt;
         avg_prev <= I_DRV.avg_freq;
         held <= next_held;
         held_ok <= next_held_ok;
         ms_seen <= next_ms_seen;
         fault <= next_fault;
         O_DRV <= next_drv;
         O_TERM <= next_term;
      end
   end

   // checks
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_NRST);

   a_disabled_quiet: assert property (!check_en |=> !O_DRV.alarm && !O_DRV.decel)
      else $error("alarm active with check disabled");
   a_hold_capture: assert property ($rose(state == cilm_pkg::ST_LOSS) && $past(I_DRV.run)
      |-> held == $past(avg_prev) && held_ok)
      else $error("held frequency not the prior average");
   a_mode1_freq: assert property (state == cilm_pkg::ST_LOSS && is_mode(eff_mode, cilm_pkg::MODE_HOLD)
      && I_DRV.run && !fault && !I_DRV.multi_speed && !ms_seen && held_ok |=> O_DRV.freq_cmd == $past(held)
      && O_DRV.alarm)
      else $error("mode 1 not running at held frequency");
   a_trip_fault: assert property (check_en && state == cilm_pkg::ST_LOSS && is_mode(eff_mode, cilm_pkg::MODE_TRIP)
      |=> fault ##1 O_DRV.shutoff)
      else $error("mode 2 loss did not trip");
   a_decel_fault: assert property (check_en && state == cilm_pkg::ST_LOSS && is_mode(eff_mode, cilm_pkg::MODE_DECEL)
      && !I_DRV.standstill && !fault |=> !fault)
      else $error("mode 3 faulted before standstill");
   a_run_clear: assert property (!I_DRV.run |=> !held_ok)
      else $error("held frequency kept after run removed");
   a_filter_wait: assert property (state == cilm_pkg::ST_NORMAL && {5'h00, hund_cnt} < loss_confirm_filter_time
      |=> state == cilm_pkg::ST_NORMAL)
      else $error("loss declared before filter time");
   a_filter_zero: assert property (loss_confirm_filter_time == 16'h0000 && check_en && state == cilm_pkg::ST_NORMAL
      && low |=> state == cilm_pkg::ST_LOSS)
      else $error("zero filter not immediate");
   a_eff_frozen: assert property (!I_DRV.run || fault |=> $stable(eff_mode) && $stable(eff_fallback))
      else $error("settings changed while stopped or faulted");
   a_comp_off: assert property (state == cilm_pkg::ST_LOSS |=> !O_DRV.comp_en)
      else $error("compensation active during loss");
   a_fallback_freq: assert property (check_en && state == cilm_pkg::ST_LOSS && is_mode(eff_mode, cilm_pkg::MODE_FALLBACK)
      && I_DRV.run && !fault && !I_DRV.multi_speed && !ms_seen
      |=> O_DRV.freq_cmd == 16'($past(eff_fallback) * 16'h000A))
      else $error("mode 4 not at fallback frequency");

   c_loss_hold: cover property ($rose(state == cilm_pkg::ST_LOSS) && is_mode(eff_mode, cilm_pkg::MODE_HOLD));
   c_decel_recover: cover property (O_DRV.decel ##[1:50] $fell(state == cilm_pkg::ST_LOSS));
   c_trip: cover property ($rose(fault) && is_mode(eff_mode, cilm_pkg::MODE_TRIP));
   c_fallback: cover property (O_DRV.alarm && is_mode(eff_mode, cilm_pkg::MODE_FALLBACK));

endmodule : cilm_top

/* File: inc/cilm_pkg.sv */
// constants, types and register map of the current input loss monitor
package cilm_pkg;
   // register byte offsets on the apb port
   localparam logic [7:0] ADDR_CFG = 8'h00;
   localparam logic [7:0] ADDR_FALLBACK = 8'h04;
   localparam logic [7:0] ADDR_FILTER = 8'h08;
   localparam logic [7:0] ADDR_OUTSEL = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // field positions
   localparam int CFG_TERM_SEL_BIT = 16;
   localparam int OUTSEL_MASK_LSB = 8;
   localparam int ST_ALARM_BIT = 0;
   localparam int ST_FAULT_BIT = 1;
   localparam int ST_LOSS_BIT = 2;
   localparam int ST_DECEL_BIT = 3;
   localparam int ST_HELD_BIT = 4;
   localparam int ST_FREQ_LSB = 16;
   // setting codes and reset values
   localparam logic [15:0] CODE_UNSET = 16'h270F;
   localparam logic [15:0] MODE_HOLD = 16'h0001;
   localparam logic [15:0] MODE_TRIP = 16'h0002;
   localparam logic [15:0] MODE_DECEL = 16'h0003;
   localparam logic [15:0] MODE_FALLBACK = 16'h0004;
   localparam logic [15:0] FALLBACK_MAX = 16'h0FA0;
   localparam logic [15:0] FILTER_MAX = 16'h03E8;
   localparam logic [15:0] FILTER_RESET = 16'h0000;
   localparam logic [7:0] FUNC_NONE = 8'h00;
   localparam logic [7:0] FUNC_ALARM_HIGH = 8'h62;
   localparam logic [7:0] FUNC_ALARM_LOW = 8'hC6;
   localparam int NUM_TERMS = 7;
   // current thresholds in 0.01 mA
   localparam logic [15:0] CUR_LOSS = 16'h00C8;
   localparam logic [15:0] CUR_RESTORE = 16'h012C;
   // filter time step of 10 ms at the 20 ns system clock
   localparam int unsigned FILTER_STEP_NS = 10000000;
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned FILTER_TICK_CYCLES = FILTER_STEP_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 19;
   localparam int HUND_W = 11;

   typedef enum logic {ST_NORMAL, ST_LOSS} cilm_state_t;

   typedef struct packed {
      logic run;
      logic multi_speed;
      logic standstill;
      logic [15:0] cur_primary;
      logic [15:0] cur_secondary;
      logic [15:0] ref_freq;
      logic [15:0] avg_freq;
      logic [15:0] ms_freq;
   } cilm_drv_in_t;

   typedef struct packed {
      logic [15:0] freq_cmd;
      logic shutoff;
      logic decel;
      logic comp_en;
      logic fault;
      logic alarm;
   } cilm_drv_out_t;
endpackage : cilm_pkg

/* File: tb/cilm_loop_src.sv */
// behavioural current-loop reference source feeding the monitor
`timescale 1ns/1ps
module cilm_loop_src (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [15:0] i_target,
   input wire logic i_slow,
   output logic [15:0] o_cur
);
   // slow mode slews 0.5 mA a cycle, like a loop that sags rather than snaps open
   localparam logic [15:0] SLEW = 16'h0032;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cur <= 16'h04B0;
      end else if (!i_slow) begin
         o_cur <= i_target;
      end else if (o_cur > i_target + SLEW) begin
         o_cur <= o_cur - SLEW;
      end else if (o_cur + SLEW < i_target) begin
         o_cur <= o_cur + SLEW;
      end else begin
         o_cur <= i_target;
      end
   end
endmodule : cilm_loop_src

/* File: tb/cilm_top_test.sv */
// self-checking testbench of the current input loss monitor
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; \
   $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module cilm_top_test;
   logic clk, nrst, psel, penable, pwrite, slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr;
   logic [15:0] tgt, src_cur;
   cilm_pkg::cilm_drv_in_t drv, drv_in;
   cilm_pkg::cilm_drv_out_t dout;
   logic [cilm_pkg::NUM_TERMS-1:0] term;
   int err_count = 0;
   int cmp_count = 0;
   int cycles = 0;

   always_comb begin
      drv_in = drv;
      drv_in.cur_primary = src_cur;
   end

   // short filter step keeps the filter scenarios to a few dozen cycles
   cilm_top #(.TICK_CYCLES(4)) DUT (.I_CLK_SYS(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
      .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
      .O_PSLVERR(pslverr), .I_DRV(drv_in), .O_DRV(dout), .O_TERM(term));
   cilm_loop_src src (.i_clk(clk), .i_nrst(nrst), .i_target(tgt), .i_slow(slow), .o_cur(src_cur));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic tally_and_finish();
      if (err_count == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // one apb transfer; read data and error taken at the edge that sees pready
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
      input logic xerr);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      `CHK(pready, 1'b1)
      `CHK(pslverr, xerr)
      if (!w) `CHK(prdata, exp)
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : acc

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : cyc

   task automatic cur(input logic [15:0] v, input int n);
      @(posedge clk);
      tgt <= v;
      cyc(n);
   endtask : cur

   task automatic clr_fault();
      cur(16'h04B0, 4);
      acc(1'b1, cilm_pkg::ADDR_STATUS, 32'h0000_0002, 32'h0, 1'b0);
      cyc(4);
   endtask : clr_fault

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      slow = 1'b0;
      tgt = 16'h04B0;
      drv = '0;
      drv.run = 1'b1;
      drv.cur_secondary = 16'h04B0;
      drv.ref_freq = 16'h1388;
      drv.avg_freq = 16'h04D2;
      drv.ms_freq = 16'h0BB8;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      acc(1'b0, cilm_pkg::ADDR_CFG, 32'h0, {16'h0, cilm_pkg::CODE_UNSET}, 1'b0);
      acc(1'b0, cilm_pkg::ADDR_FALLBACK, 32'h0, {16'h0, cilm_pkg::CODE_UNSET}, 1'b0);
      acc(1'b0, cilm_pkg::ADDR_FILTER, 32'h0, 32'h0, 1'b0);
      acc(1'b0, 8'h20, 32'h0, 32'h0, 1'b1);
      cur(16'h00C8, 4);
      `CHK(dout.alarm, 1'b0)
      `CHK(dout.fault, 1'b0)
      cur(16'h04B0, 4);
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h5, 32'h0, 1'b1);
      acc(1'b0, cilm_pkg::ADDR_CFG, 32'h0, {16'h0, cilm_pkg::CODE_UNSET}, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_FALLBACK, 32'h0FA1, 32'h0, 1'b1);
      acc(1'b1, cilm_pkg::ADDR_FILTER, 32'h03E9, 32'h0, 1'b1);
      acc(1'b1, cilm_pkg::ADDR_OUTSEL, 32'h0000_0162, 32'h0, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h1, 32'h0, 1'b0);
      cyc(4);
      `CHK(dout.freq_cmd, 16'h1388)
      cur(16'h00C8, 4);
      `CHK(dout.alarm, 1'b1)
      `CHK(dout.freq_cmd, 16'h04D2)
      `CHK(dout.comp_en, 1'b0)
      `CHK(term[0], 1'b1)
      @(posedge clk);
      drv.avg_freq <= 16'h0999;
      cyc(4);
      `CHK(dout.freq_cmd, 16'h04D2)
      cur(16'h012C, 4);
      `CHK(dout.alarm, 1'b1)
      cur(16'h012D, 4);
      `CHK(dout.alarm, 1'b0)
      `CHK(dout.freq_cmd, 16'h1388)
      `CHK(dout.comp_en, 1'b1)
      cur(16'h00C8, 4);
      @(posedge clk);
      drv.multi_speed <= 1'b1;
      cyc(4);
      `CHK(dout.freq_cmd, 16'h0BB8)
      @(posedge clk);
      drv.multi_speed <= 1'b0;
      cyc(4);
      `CHK(dout.freq_cmd, 16'h0000)
      @(posedge clk);
      drv.run <= 1'b0;
      cyc(4);
      `CHK(dout.freq_cmd, 16'h0000)
      @(posedge clk);
      drv.run <= 1'b1;
      cyc(4);
      `CHK(dout.freq_cmd === 16'h0999, 1'b0)
      cur(16'h04B0, 4);
      // secondary terminal with the inverted alarm output
      acc(1'b1, cilm_pkg::ADDR_OUTSEL, 32'h0000_01C6, 32'h0, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h0001_0001, 32'h0, 1'b0);
      cyc(4);
      `CHK(term[0], 1'b1)
      @(posedge clk);
      drv.cur_secondary <= 16'h00C8;
      cyc(4);
      `CHK(dout.alarm, 1'b1)
      `CHK(term[0], 1'b0)
      @(posedge clk);
      drv.cur_secondary <= 16'h04B0;
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h2, 32'h0, 1'b0);
      cur(16'h00C8, 5);
      `CHK(dout.fault, 1'b1)
      `CHK(dout.shutoff, 1'b1)
      // a mode written while faulted must not act before the clear
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h1, 32'h0, 1'b0);
      cyc(4);
      `CHK(dout.alarm, 1'b0)
      clr_fault();
      `CHK(dout.fault, 1'b0)
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h3, 32'h0, 1'b0);
      cur(16'h00C8, 4);
      `CHK({dout.alarm, dout.decel, dout.fault}, 3'b110)
      cur(16'h012C, 4);
      `CHK({dout.alarm, dout.decel, dout.fault}, 3'b000)
      `CHK(dout.freq_cmd, 16'h1388)
      cur(16'h00C8, 4);
      @(posedge clk);
      drv.standstill <= 1'b1;
      cyc(5);
      `CHK(dout.fault, 1'b1)
      @(posedge clk);
      drv.standstill <= 1'b0;
      clr_fault();
      acc(1'b1, cilm_pkg::ADDR_FALLBACK, 32'h0064, 32'h0, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h4, 32'h0, 1'b0);
      cur(16'h00C8, 4);
      `CHK(dout.alarm, 1'b1)
      `CHK(dout.freq_cmd, 16'h03E8)
      // status: frequency, held valid, loss and alarm set
      acc(1'b0, cilm_pkg::ADDR_STATUS, 32'h0, 32'h03E8_0015, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_FALLBACK, 32'h00C8, 32'h0, 1'b0);
      cyc(4);
      `CHK(dout.freq_cmd, 16'h07D0)
      cur(16'h012C, 4);
      `CHK(dout.alarm, 1'b0)
      acc(1'b1, cilm_pkg::ADDR_FALLBACK, 32'h270F, 32'h0, 1'b0);
      cur(16'h00C8, 4);
      `CHK(dout.alarm, 1'b0)
      cur(16'h04B0, 4);
      // two filter steps of four cycles each
      acc(1'b1, cilm_pkg::ADDR_CFG, 32'h1, 32'h0, 1'b0);
      acc(1'b1, cilm_pkg::ADDR_FILTER, 32'h2, 32'h0, 1'b0);
      cur(16'h00C8, 3);
      `CHK(dout.alarm, 1'b0)
      cyc(20);
      `CHK(dout.alarm, 1'b1)
      cur(16'h04B0, 3);
      `CHK(dout.alarm, 1'b1)
      cyc(20);
      `CHK(dout.alarm, 1'b0)
      acc(1'b1, cilm_pkg::ADDR_FILTER, 32'h0, 32'h0, 1'b0);
      @(posedge clk);
      slow <= 1'b1;
      cur(16'h00C8, 30);
      `CHK(dout.alarm, 1'b1)
      tally_and_finish();
   end
endmodule : cilm_top_test
